// File: logic/omc_consts.svh
// Offsets, fields, control reset value, event bits and response codes of the operating mode controller
`ifndef OMC_CONSTS_SVH
`define OMC_CONSTS_SVH
`define OMC_OFF_CTRL 8'h00
`define OMC_OFF_STAT 8'h04
`define OMC_OFF_EVT 8'h08
`define OMC_OFF_DBG 8'h0C
`define OMC_CTRL_STOP_ENABLE_BIT 0
`define OMC_CTRL_PARTIAL_POWERDOWN_SELECT 1
`define OMC_CTRL_LOW_VOLTAGE_DETECT_ENABLE 2
`define OMC_CTRL_LOW_VOLTAGE_DETECT_STOP_ENABLE 3
`define OMC_CTRL_DEBUG_ENABLE_BIT 4
`define OMC_CTRL_ACK 5
`define OMC_CTRL_RST 32'h0000_0000
`define OMC_EVT_WAIT 0
`define OMC_EVT_STOP 1
`define OMC_EVT_DEBUG_HALT_INSTRUCTION 2
`define OMC_EVT_BRK 3
`define OMC_EVT_HALT 4
`define OMC_EVT_GO 5
`define OMC_EVT_TRACE 6
`define OMC_RESP_OKAY 2'h0
`define OMC_RESP_SLVERR 2'h2
`define OMC_DBG_ERR_STOPWAIT 8'hC1
`define OMC_DBG_OK 8'h00
`define OMC_DBG_REFUSED 8'hEE
`endif

// File: logic/omc_pkg.sv
// Types of the operating mode controller
package omc_pkg;
	typedef enum logic [2:0] {
		OMC_RUN, OMC_HALT, OMC_WAIT, OMC_STOP2, OMC_STOP3
	} omc_mode_t;
	typedef enum logic [3:0] {
		OMC_CMD_NONE, OMC_CMD_MEM, OMC_CMD_MEM_STAT, OMC_CMD_DBGREG, OMC_CMD_HALT,
		OMC_CMD_CPUREG, OMC_CMD_TRACE, OMC_CMD_GO
	} omc_cmd_t;
	typedef struct packed {
		logic valid;
		omc_cmd_t cmd;
	} omc_dbg_req_t;
	typedef struct packed {
		logic valid;
		logic accept;
		logic err_stopwait;
		logic [7:0] code;
	} omc_dbg_rsp_t;
	typedef struct packed {
		logic cpu_clk_en;
		logic sys_clk_en;
		logic dbg_clk_en;
		logic reg_full;
		logic clear_imask;
		logic stack_irq;
		logic reset_vector;
		logic periph_reset;
		logic illegal_reset;
		logic pin_latch;
	} omc_ctl_t;
endpackage

// File: logic/omc_cmd_filter.sv
// Debug command acceptance per operating mode
module omc_cmd_filter
	import omc_pkg::*;
(
	input omc_mode_t mode,
	input omc_cmd_t cmd,
	output logic accept,
	output logic err_stopwait
);
	always_comb begin
		accept = 1'b0;
		err_stopwait = 1'b0;
		case (mode)
			OMC_RUN: begin
				accept = (cmd == OMC_CMD_MEM) || (cmd == OMC_CMD_MEM_STAT)
					|| (cmd == OMC_CMD_DBGREG) || (cmd == OMC_CMD_HALT);
			end
			OMC_HALT: begin
				accept = (cmd != OMC_CMD_NONE);
			end
			OMC_WAIT, OMC_STOP2, OMC_STOP3: begin
				accept = (cmd == OMC_CMD_HALT) || (cmd == OMC_CMD_MEM_STAT);
				err_stopwait = (cmd == OMC_CMD_MEM_STAT);
			end
			default: begin
				accept = 1'b0;
			end
		endcase
	end
endmodule // omc_cmd_filter

// File: logic/omc_top.sv
// Operating mode controller: run, debug halt, wait, stop2, stop3 with AXI4-Lite registers
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`include "omc_consts.svh"
module omc_top
	import omc_pkg::*;
#(
	parameter int PIN_W = 8
) (
	input logic clk,
	input logic srst,
	input logic [7:0] s_axi_awaddr,
	input logic s_axi_awvalid,
	output logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [7:0] s_axi_araddr,
	input logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic debug_mode_select_pin,
	input logic reset_pin_n,
	input logic external_int_n,
	input logic periodic_wakeup_interrupt,
	input logic low_voltage_irq,
	input logic converter_irq,
	input logic keypad_interrupt,
	input logic cpu_irq,
	input logic debug_halt_instruction,
	input logic wait_instruction,
	input logic stop_instruction,
	input logic background_debug_controller,
	input logic on_chip_debug_module,
	input omc_dbg_req_t dbg_req,
	input logic [PIN_W-1:0] port_pin_out,
	output omc_dbg_rsp_t dbg_rsp,
	output omc_ctl_t ctl,
	output omc_mode_t mode,
	output logic [PIN_W-1:0] pin_out
);
	if (PIN_W < 1 || PIN_W > 32) begin : g_bad_pin_w
		$error("PIN_W must be 1 to 32");
	end

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	logic [5:0] ctrl_reg;
	logic partial_powerdown_flag_reg;
	logic [6:0] evt_reg;
	logic [7:0] dbg_code_reg;
	logic [7:0] aw_reg;
	logic [31:0] w_reg;
	logic aw_have_reg;
	logic w_have_reg;
	logic wr_go;
	logic ack_wr;
	logic [PIN_W-1:0] pin_hold_reg;
	logic latch_reg;
	logic mode_pin_reg;
	logic rst_d_reg;
	logic stop2_wake;

	assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign ack_wr = wr_go && (aw_reg == `OMC_OFF_CTRL) && w_reg[`OMC_CTRL_ACK];

	always_ff @(posedge clk) begin
		if (srst) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_reg <= 8'h00;
			w_reg <= 32'h0000_0000;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `OMC_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_reg && s_axi_awvalid && !s_axi_awready;
			s_axi_wready <= !w_have_reg && s_axi_wvalid && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				aw_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				w_reg <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
					{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_reg == `OMC_OFF_CTRL || aw_reg == `OMC_OFF_STAT
					|| aw_reg == `OMC_OFF_EVT || aw_reg == `OMC_OFF_DBG)
					? `OMC_RESP_OKAY : `OMC_RESP_SLVERR;
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `OMC_RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `OMC_RESP_OKAY;
				case (s_axi_araddr)
					`OMC_OFF_CTRL: s_axi_rdata <= {26'h0, 1'b0, ctrl_reg[4:0]};
					`OMC_OFF_STAT: s_axi_rdata <= {24'h0, latch_reg, mode_pin_reg,
						partial_powerdown_flag_reg, 2'h0, mode};
					`OMC_OFF_EVT: s_axi_rdata <= {25'h0, evt_reg};
					`OMC_OFF_DBG: s_axi_rdata <= {24'h0, dbg_code_reg};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `OMC_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Control bits; acknowledge bit is write-only and reads zero
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_reg <= 6'(`OMC_CTRL_RST);
		end else if (stop2_wake) begin
			ctrl_reg <= 6'(`OMC_CTRL_RST);
		end else if (wr_go && aw_reg == `OMC_OFF_CTRL) begin
			ctrl_reg <= {1'b0, w_reg[4:0]};
		end
	end

	// ------------------------------------------------------------
	// Mode sequencing
	// ------------------------------------------------------------
	logic halt_cmd;
	logic stop_irq;
	logic sel_stop2;
	logic accept;
	logic err_sw;

	omc_cmd_filter omc_cmd_filter_inst (
		.mode(mode),
		.cmd(dbg_req.cmd),
		.accept(accept),
		.err_stopwait(err_sw)
	);

	assign halt_cmd = dbg_req.valid && dbg_req.cmd == OMC_CMD_HALT;
	assign stop_irq = periodic_wakeup_interrupt || low_voltage_irq || converter_irq
		|| !external_int_n || keypad_interrupt;
	assign sel_stop2 = ctrl_reg[`OMC_CTRL_PARTIAL_POWERDOWN_SELECT]
		&& !(ctrl_reg[`OMC_CTRL_LOW_VOLTAGE_DETECT_ENABLE] && ctrl_reg[`OMC_CTRL_LOW_VOLTAGE_DETECT_STOP_ENABLE])
		&& !ctrl_reg[`OMC_CTRL_DEBUG_ENABLE_BIT];
	assign stop2_wake = (mode == OMC_STOP2)
		&& (!reset_pin_n || !external_int_n || periodic_wakeup_interrupt);

	always_ff @(posedge clk) begin
		if (srst) begin
			rst_d_reg <= 1'b1;
			mode_pin_reg <= 1'b1;
		end else begin
			rst_d_reg <= 1'b0;
			if (rst_d_reg) begin
				mode_pin_reg <= debug_mode_select_pin;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mode <= OMC_RUN;
		end else begin
			case (mode)
				OMC_RUN: begin
					if ((rst_d_reg && !debug_mode_select_pin) || halt_cmd
						|| debug_halt_instruction || background_debug_controller
						|| on_chip_debug_module) begin
						mode <= OMC_HALT;
					end else if (wait_instruction) begin
						mode <= OMC_WAIT;
					end else if (stop_instruction && ctrl_reg[`OMC_CTRL_STOP_ENABLE_BIT]) begin
						mode <= sel_stop2 ? OMC_STOP2 : OMC_STOP3;
					end
				end
				OMC_HALT: begin
					if (dbg_req.valid && dbg_req.cmd == OMC_CMD_GO) begin
						mode <= OMC_RUN;
					end
				end
				OMC_WAIT: begin
					if (halt_cmd) begin
						mode <= OMC_HALT;
					end else if (cpu_irq) begin
						mode <= OMC_RUN;
					end
				end
				OMC_STOP2: begin
					if (stop2_wake) begin
						mode <= OMC_RUN;
					end
				end
				OMC_STOP3: begin
					if (halt_cmd && ctrl_reg[`OMC_CTRL_DEBUG_ENABLE_BIT]) begin
						mode <= OMC_HALT;
					end else if (!reset_pin_n || stop_irq) begin
						mode <= OMC_RUN;
					end
				end
				default: begin
					mode <= OMC_RUN;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Clock, reset and vector controls
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			ctl <= '0;
		end else begin
			ctl.cpu_clk_en <= (mode == OMC_RUN) && !wait_instruction;
			ctl.sys_clk_en <= (mode == OMC_RUN) || (mode == OMC_HALT)
				|| (mode == OMC_WAIT);
			ctl.dbg_clk_en <= (mode != OMC_STOP2 && mode != OMC_STOP3)
				|| ctrl_reg[`OMC_CTRL_DEBUG_ENABLE_BIT];
			ctl.reg_full <= (mode != OMC_STOP2 && mode != OMC_STOP3)
				|| ctrl_reg[`OMC_CTRL_DEBUG_ENABLE_BIT] || ctrl_reg[`OMC_CTRL_LOW_VOLTAGE_DETECT_STOP_ENABLE];
			ctl.clear_imask <= (mode == OMC_RUN) && wait_instruction;
			ctl.stack_irq <= ((mode == OMC_WAIT) && cpu_irq && !halt_cmd)
				|| ((mode == OMC_STOP3) && reset_pin_n && stop_irq
				&& !(halt_cmd && ctrl_reg[`OMC_CTRL_DEBUG_ENABLE_BIT]));
			ctl.reset_vector <= stop2_wake
				|| ((mode == OMC_STOP3) && !reset_pin_n);
			ctl.periph_reset <= stop2_wake;
			ctl.illegal_reset <= (mode == OMC_RUN) && stop_instruction && !wait_instruction
				&& !ctrl_reg[`OMC_CTRL_STOP_ENABLE_BIT] && !debug_halt_instruction;
			ctl.pin_latch <= latch_reg;
		end
	end

	// ------------------------------------------------------------
	// Pin latch and powerdown flag
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			latch_reg <= 1'b0;
		end else if (mode == OMC_RUN && stop_instruction && ctrl_reg[`OMC_CTRL_STOP_ENABLE_BIT]
			&& sel_stop2 && !wait_instruction) begin
			latch_reg <= 1'b1;
		end else if (ack_wr && mode != OMC_STOP2) begin
			latch_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pin_hold_reg <= '0;
		end else if (!latch_reg) begin
			pin_hold_reg <= port_pin_out;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pin_out <= '0;
		end else begin
			pin_out <= latch_reg ? pin_hold_reg : port_pin_out;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			partial_powerdown_flag_reg <= 1'b0;
		end else if (stop2_wake) begin
			partial_powerdown_flag_reg <= 1'b1;
		end else if (ack_wr) begin
			partial_powerdown_flag_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Debug answers and sticky events
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			dbg_rsp <= '0;
			dbg_code_reg <= `OMC_DBG_OK;
		end else begin
			dbg_rsp.valid <= dbg_req.valid;
			dbg_rsp.accept <= dbg_req.valid && accept;
			dbg_rsp.err_stopwait <= dbg_req.valid && err_sw;
			dbg_rsp.code <= !dbg_req.valid ? `OMC_DBG_OK
				: err_sw ? `OMC_DBG_ERR_STOPWAIT
				: accept ? `OMC_DBG_OK : `OMC_DBG_REFUSED;
			if (dbg_req.valid) begin
				dbg_code_reg <= err_sw ? `OMC_DBG_ERR_STOPWAIT
					: accept ? `OMC_DBG_OK : `OMC_DBG_REFUSED;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			evt_reg <= '0;
		end else begin
			evt_reg <= (wr_go && aw_reg == `OMC_OFF_EVT) ? (evt_reg & ~w_reg[6:0]) : evt_reg;
			if (mode == OMC_RUN && wait_instruction) evt_reg[`OMC_EVT_WAIT] <= 1'b1;
			if (mode == OMC_RUN && stop_instruction) evt_reg[`OMC_EVT_STOP] <= 1'b1;
			if (debug_halt_instruction) evt_reg[`OMC_EVT_DEBUG_HALT_INSTRUCTION] <= 1'b1;
			if (background_debug_controller || on_chip_debug_module) begin
				evt_reg[`OMC_EVT_BRK] <= 1'b1;
			end
			if (halt_cmd && accept) evt_reg[`OMC_EVT_HALT] <= 1'b1;
			if (mode == OMC_HALT && dbg_req.valid && dbg_req.cmd == OMC_CMD_GO) begin
				evt_reg[`OMC_EVT_GO] <= 1'b1;
			end
			if (mode == OMC_HALT && dbg_req.valid && dbg_req.cmd == OMC_CMD_TRACE) begin
				evt_reg[`OMC_EVT_TRACE] <= 1'b1;
			end
		end
	end
endmodule // omc_top

// File: dv/omc_top_props.sv
// Port checker of the operating mode controller
module omc_top_props
	import omc_pkg::*;
#(
	parameter int PIN_W = 8
) (
	input logic clk,
	input logic srst,
	input logic debug_mode_select_pin,
	input logic external_int_n,
	input logic reset_pin_n,
	input logic periodic_wakeup_interrupt,
	input logic cpu_irq,
	input logic wait_instruction,
	input omc_dbg_req_t dbg_req,
	input omc_dbg_rsp_t dbg_rsp,
	input omc_ctl_t ctl,
	input omc_mode_t mode,
	input logic [PIN_W-1:0] pin_out
);
	// ----
	// Sequences
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence in_stop2;
		mode == OMC_STOP2 && $past(mode) == OMC_STOP2;
	endsequence
	sequence halt_req;
		dbg_req.valid && dbg_req.cmd == OMC_CMD_HALT && mode inside {OMC_RUN, OMC_WAIT}
			&& !wait_instruction;
	endsequence
	// ----
	// Assertions
	// ----
	pin_sample_a: assert property ($fell(srst) && !debug_mode_select_pin |-> ##[1:2] mode == OMC_HALT)
		else $error("mode pin low did not give debug halt");
	halt_cmd_a: assert property (halt_req |=> mode == OMC_HALT)
		else $error("halt command did not enter debug halt");
	halt_only_a: assert property (dbg_req.valid && dbg_req.cmd inside {OMC_CMD_CPUREG,
		OMC_CMD_TRACE, OMC_CMD_GO} && mode != OMC_HALT
		|=> dbg_rsp.valid && !dbg_rsp.accept && dbg_rsp.code == 8'hEE)
		else $error("halt-only command accepted outside halt");
	non_intr_a: assert property (dbg_req.valid && dbg_req.cmd inside {OMC_CMD_MEM,
		OMC_CMD_MEM_STAT, OMC_CMD_DBGREG, OMC_CMD_HALT} && mode inside {OMC_RUN, OMC_HALT}
		|=> dbg_rsp.accept && !dbg_rsp.err_stopwait)
		else $error("non-intrusive command refused");
	stop_wait_a: assert property (dbg_req.valid && dbg_req.cmd == OMC_CMD_MEM_STAT
		&& mode inside {OMC_WAIT, OMC_STOP3}
		|=> dbg_rsp.accept && dbg_rsp.err_stopwait && dbg_rsp.code == 8'hC1)
		else $error("status command missed stop or wait error");
	wait_entry_a: assert property (mode == OMC_RUN && wait_instruction && !dbg_req.valid
		|=> mode == OMC_WAIT ##[0:1] (ctl.clear_imask && !ctl.cpu_clk_en && ctl.sys_clk_en))
		else $error("wait entry wrong");
	wait_irq_a: assert property (mode == OMC_WAIT && cpu_irq && !dbg_req.valid
		|=> mode == OMC_RUN ##[0:1] ctl.stack_irq)
		else $error("interrupt did not leave wait with stacking");
	stop2_clk_a: assert property (in_stop2 |-> !ctl.cpu_clk_en && !ctl.sys_clk_en)
		else $error("clocks running in deep power-down");
	pin_hold_a: assert property (ctl.pin_latch && $past(ctl.pin_latch) |-> $stable(pin_out))
		else $error("latched pins moved");
	stop2_wake_a: assert property (mode == OMC_STOP2 && !external_int_n
		|=> mode == OMC_RUN ##[0:1] ctl.reset_vector)
		else $error("external interrupt wake from deep power-down wrong");
	stop2_stay_a: assert property (mode == OMC_STOP2 && reset_pin_n && external_int_n
		&& !periodic_wakeup_interrupt |=> mode == OMC_STOP2)
		else $error("deep power-down left without wake source");
endmodule // omc_top_props

// File: dv/omc_dbg_host.sv
// Debug host model that issues serial debug commands
module omc_dbg_host
	import omc_pkg::*;
(
	input logic clk,
	output omc_dbg_req_t dbg_req
);
	initial dbg_req = '0;
	// Holds one command for exactly one sampling edge
	task automatic issue(input omc_cmd_t c);
		@(posedge clk);
		dbg_req <= '{valid: 1'b1, cmd: c};
		@(posedge clk);
		dbg_req <= '0;
	endtask
endmodule // omc_dbg_host

// File: dv/omc_top_tb_top.sv
// Testbench of the operating mode controller
`include "omc_consts.svh"
module omc_top_tb_top
	import omc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Signals
	// ----
	logic clk = 0;
	logic srst = 1;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
	logic [31:0] s_axi_rdata, rd;
	logic debug_mode_select_pin = 0, reset_pin_n = 1, external_int_n = 1, cpu_irq = 0;
	logic periodic_wakeup_interrupt = 0, low_voltage_irq = 0, converter_irq = 0;
	logic keypad_interrupt = 0, debug_halt_instruction = 0, wait_instruction = 0;
	logic stop_instruction = 0, background_debug_controller = 0, on_chip_debug_module = 0;
	logic [7:0] port_pin_out = 8'hA5, pin_out;
	logic [2:0] seen = '0;
	omc_dbg_req_t dbg_req;
	omc_dbg_rsp_t dbg_rsp;
	omc_ctl_t ctl;
	omc_mode_t mode;
	int num_errors = 0, checks = 0, cycles = 0;
	omc_top #(.PIN_W(8)) omc_top_inst (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.debug_mode_select_pin, .reset_pin_n, .external_int_n, .periodic_wakeup_interrupt,
		.low_voltage_irq, .converter_irq, .keypad_interrupt, .cpu_irq, .debug_halt_instruction,
		.wait_instruction, .stop_instruction, .background_debug_controller,
		.on_chip_debug_module, .dbg_req, .port_pin_out, .dbg_rsp, .ctl, .mode, .pin_out);
	omc_dbg_host omc_dbg_host_inst (.clk, .dbg_req);
	initial forever #4 clk = ~clk;
	always @(posedge clk) seen <= seen | {ctl.reset_vector, ctl.stack_irq, ctl.illegal_reset};
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_of_test;
		end
	end
	// ----
	// Tasks
	// ----
	task end_of_test;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task check(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		br = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		axi_rd(a, rd, rr);
		check("rdata", e, rd & m);
	endtask
	task dbg(input omc_cmd_t c, input logic acc, input logic [7:0] code);
		omc_dbg_host_inst.issue(c);
		#1;
		check("accept", acc, dbg_rsp.accept);
		check("code", code, dbg_rsp.code);
	endtask
	task md(input omc_mode_t m);
		check("mode", m, mode);
	endtask
	task pulse(input int k);
		@(posedge clk);
		case (k)
			0: wait_instruction <= 1;
			1: stop_instruction <= 1;
			2: on_chip_debug_module <= 1;
			3: cpu_irq <= 1;
			4: external_int_n <= 0;
			6: reset_pin_n <= 0;
			default: keypad_interrupt <= 1;
		endcase
		@(posedge clk);
		{wait_instruction, stop_instruction, on_chip_debug_module} <= '0;
		{cpu_irq, keypad_interrupt, external_int_n, reset_pin_n} <= 4'h3;
		#1;
	endtask
	// ----
	// Tests
	// ----
	initial begin
		repeat (4) @(posedge clk);
		srst <= 0;
		repeat (2) @(posedge clk);
		#1;
		md(OMC_HALT);
		dbg(OMC_CMD_CPUREG, 1, 8'h00);
		dbg(OMC_CMD_TRACE, 1, 8'h00);
		dbg(OMC_CMD_GO, 1, 8'h00);
		md(OMC_RUN);
		rd_chk(`OMC_OFF_CTRL, 32'h0, '1);
		axi_rd(8'h10, rd, rr);
		check("rresp", `OMC_RESP_SLVERR, rr);
		axi_wr(8'h10, 32'h1F);
		check("bresp", `OMC_RESP_SLVERR, br);
		rd_chk(`OMC_OFF_CTRL, 32'h0, '1);
		for (int c = 1; c < 8; c++) if (c != 4) dbg(omc_cmd_t'(c), c < 4, c < 4 ? 8'h00 : 8'hEE);
		rd_chk(`OMC_OFF_DBG, 32'hEE, '1);
		dbg(OMC_CMD_HALT, 1, 8'h00);
		md(OMC_HALT);
		dbg(OMC_CMD_MEM, 1, 8'h00);
		dbg(OMC_CMD_GO, 1, 8'h00);
		pulse(2);
		md(OMC_HALT);
		dbg(OMC_CMD_GO, 1, 8'h00);
		pulse(0);
		md(OMC_WAIT);
		@(posedge clk);
		#1;
		check("cpu_clk", 0, ctl.cpu_clk_en);
		check("sys_clk", 1, ctl.sys_clk_en);
		dbg(OMC_CMD_MEM_STAT, 1, 8'hC1);
		dbg(OMC_CMD_MEM, 0, 8'hEE);
		dbg(OMC_CMD_HALT, 1, 8'h00);
		md(OMC_HALT);
		dbg(OMC_CMD_GO, 1, 8'h00);
		pulse(0);
		pulse(3);
		md(OMC_RUN);
		pulse(1);
		md(OMC_RUN);
		check("illegal_reset", 1, ctl.illegal_reset);
		axi_wr(`OMC_OFF_CTRL, 32'h3);
		check("bresp", `OMC_RESP_OKAY, br);
		pulse(1);
		md(OMC_STOP2);
		port_pin_out <= 8'h3C;
		repeat (3) @(posedge clk);
		#1;
		check("pins", 8'hA5, pin_out);
		check("sys_clk", 0, ctl.sys_clk_en);
		pulse(4);
		md(OMC_RUN);
		check("reset_vector", 1, ctl.reset_vector);
		check("periph_reset", 1, ctl.periph_reset);
		rd_chk(`OMC_OFF_STAT, 32'hA0, 32'hFFFF_FFBF);
		rd_chk(`OMC_OFF_CTRL, 32'h0, '1);
		axi_wr(`OMC_OFF_CTRL, 32'h0);
		rd_chk(`OMC_OFF_STAT, 32'hA0, 32'hFFFF_FFBF);
		check("pins", 8'hA5, pin_out);
		axi_wr(`OMC_OFF_CTRL, 32'h20);
		rd_chk(`OMC_OFF_STAT, 32'h0, 32'hFFFF_FFBF);
		check("pins", 8'h3C, pin_out);
		axi_wr(`OMC_OFF_CTRL, 32'hF);
		pulse(1);
		md(OMC_STOP3);
		repeat (3) @(posedge clk);
		#1;
		check("pins", 8'h3C, pin_out);
		pulse(5);
		md(OMC_RUN);
		check("stack_irq", 1, ctl.stack_irq);
		axi_wr(`OMC_OFF_CTRL, 32'h13);
		pulse(1);
		md(OMC_STOP3);
		@(posedge clk);
		#1;
		check("dbg_clk", 1, ctl.dbg_clk_en);
		check("reg_full", 1, ctl.reg_full);
		dbg(OMC_CMD_MEM_STAT, 1, 8'hC1);
		dbg(OMC_CMD_HALT, 1, 8'h00);
		md(OMC_HALT);
		dbg(OMC_CMD_CPUREG, 1, 8'h00);
		dbg(OMC_CMD_GO, 1, 8'h00);
		axi_wr(`OMC_OFF_CTRL, 32'h1);
		pulse(1);
		md(OMC_STOP3);
		pulse(6);
		md(OMC_RUN);
		check("reset_vector", 1, ctl.reset_vector);
		check("stack_irq", 0, ctl.stack_irq);
		check("events", 3'b111, seen);
		end_of_test;
	end
endmodule // omc_top_tb_top
bind omc_top omc_top_props #(.PIN_W(PIN_W)) omc_top_props_inst (.clk, .srst,
	.debug_mode_select_pin, .external_int_n, .reset_pin_n, .periodic_wakeup_interrupt,
	.cpu_irq, .wait_instruction, .dbg_req, .dbg_rsp, .ctl, .mode, .pin_out);
